// ===== src/pd_source_attach_policy_regs.vh
// Constants for the source attach policy block.
// Assumes a 25 MHz core clock; included by the policy design file only.
`ifndef PD_SOURCE_ATTACH_POLICY_REGS_VH
`define PD_SOURCE_ATTACH_POLICY_REGS_VH
// Voltage codes in millivolts (16 bit)
`define VBUS_5V_MV 16'h1388
`define VBUS_MIN_MV 16'h128e
`define VBUS_MAX_MV 16'h157c
// Current codes in milliamps (16 bit)
`define CURR_3A_MA 16'h0bb8
// Type-C advertisement code: 2'h3 means 3 A
`define ADV_3A 2'h3
`define ADV_OFF 2'h0
// Legacy data-line signalling codes
`define LEG_NONE 2'h0
`define LEG_SHORT 2'h1
`define LEG_DIVIDER 2'h2
// Time before resend after reject, in microseconds
`define RESEND_US 32'h10
`define CLK_MHZ 32'h19
// Time to wait for a first request, in microseconds
`define NO_ANSWER_US 32'h1388
`define ADC_BITS 32'ha
`endif

// ===== src/feedback_servo.v
// Regulator feedback servo: steps a drive code toward the target voltage.
// Assumes sense inputs are already synchronised to core_clk_in.
`timescale 1ns/100ps
`default_nettype none
module feedback_servo #(
  parameter WIDTH = 16
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire [WIDTH-1:0] target_mv_in,
  input wire [WIDTH-1:0] sense_mv_in,
  output reg [WIDTH-1:0] drive_out
);
  // Integrating step; slow but never oscillates faster than the loop filter
  always @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      drive_out <= {WIDTH{1'b0}};
    end else if (sense_mv_in < target_mv_in && drive_out != {WIDTH{1'b1}}) begin
      drive_out <= drive_out + {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (sense_mv_in > target_mv_in && drive_out != {WIDTH{1'b0}}) begin
      drive_out <= drive_out - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// ===== src/pd_source_attach_policy.v
// Source attach policy: load switch, initial 5 V, capabilities, contracts,
// feedback drive, current protection and legacy data-line signalling.
// Assumes analog detectors, ADC and PD message layer sit outside this block.
`timescale 1ns/100ps
`default_nettype none
`include "pd_source_attach_policy_regs.vh"
module pd_source_attach_policy #(
  parameter NO_ANSWER_CYCLES = `NO_ANSWER_US * `CLK_MHZ
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire attach_in,
  input wire orient_cc2_in,
  input wire cc_ovp_in,
  input wire request_valid_in,
  input wire request_legal_in,
  input wire request_pps_in,
  input wire [15:0] request_mv_in,
  input wire [15:0] request_ma_in,
  input wire status_req_in,
  input wire [15:0] voltage_feedback_sense_in,
  input wire [15:0] current_sense_ma_in,
  input wire [9:0] adc_current_in,
  input wire [9:0] adc_rail_in,
  input wire legacy_divider_cfg_in,
  input wire cable_comp_cfg_in,
  input wire dm_dp_divider_seen_in,
  output reg gate_drive_out,
  output reg discharge_out,
  output reg [1:0] cc_adv_out,
  output reg [15:0] vbus_target_out,
  output reg send_caps_out,
  output reg caps_on_cc2_out,
  output reg send_reject_out,
  output reg send_accept_out,
  output reg send_status_out,
  output reg [9:0] status_current_out,
  output reg [9:0] status_voltage_out,
  output reg [15:0] regulator_feedback_drive_out,
  output reg current_limit_out,
  output reg ocp_fault_out,
  output reg [1:0] legacy_mode_out,
  output reg disabled_out
);
  localparam [2:0] ST_UNATT = 3'h0;
  localparam [2:0] ST_CAPS = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_TYPEC = 3'h3;
  localparam [2:0] ST_CONTRACT = 3'h4;
  localparam [2:0] ST_REJECT = 3'h5;
  localparam [2:0] ST_DISABLED = 3'h6;
  localparam [31:0] RESEND_CYCLES = `RESEND_US * `CLK_MHZ;
  localparam [31:0] NO_ANSWER_LIM = NO_ANSWER_CYCLES;

  // Attach, over-voltage and divider-seen inputs pass two flops before use
  reg attach_s1, attach_s2, ovp_s1, ovp_s2, div_s1, div_s2;
  always @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      attach_s1 <= 1'b0;
      attach_s2 <= 1'b0;
      ovp_s1 <= 1'b0;
      ovp_s2 <= 1'b0;
      div_s1 <= 1'b0;
      div_s2 <= 1'b0;
    end else begin
      attach_s1 <= attach_in;
      attach_s2 <= attach_s1;
      ovp_s1 <= cc_ovp_in;
      ovp_s2 <= ovp_s1;
      div_s1 <= dm_dp_divider_seen_in;
      div_s2 <= div_s1;
    end
  end

  reg [2:0] state;
  reg [31:0] timer;
  reg programmable_supply_contract;
  reg [15:0] limit_ma;
  reg [15:0] comp_mv;
  wire [15:0] servo_drive;

  // Cable compensation adds roughly 1 mV per 16 mA of load
  always @* begin
    comp_mv = cable_comp_cfg_in ? {4'h0, current_sense_ma_in[15:4]} : 16'h0000;
  end

  // Policy state machine
  always @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state <= ST_UNATT;
      timer <= 32'h0;
      programmable_supply_contract <= 1'b0;
      limit_ma <= `CURR_3A_MA;
      gate_drive_out <= 1'b0;
      discharge_out <= 1'b1;
      cc_adv_out <= `ADV_3A;
      vbus_target_out <= `VBUS_5V_MV;
      send_caps_out <= 1'b0;
      caps_on_cc2_out <= 1'b0;
      send_reject_out <= 1'b0;
      send_accept_out <= 1'b0;
      disabled_out <= 1'b0;
    end else begin
      send_caps_out <= 1'b0;
      send_reject_out <= 1'b0;
      send_accept_out <= 1'b0;
      timer <= timer + 32'h1;
      if (ovp_s2) begin
        state <= ST_DISABLED;
        gate_drive_out <= 1'b0;
        discharge_out <= 1'b1;
        cc_adv_out <= `ADV_OFF;
        disabled_out <= 1'b1;
        // Drop the contract so a later attach starts from plain 5 V
        vbus_target_out <= `VBUS_5V_MV;
        programmable_supply_contract <= 1'b0;
        limit_ma <= `CURR_3A_MA;
      end else if (!attach_s2 && state != ST_UNATT && state != ST_DISABLED) begin
        state <= ST_UNATT;
        gate_drive_out <= 1'b0;
        discharge_out <= 1'b1;
        vbus_target_out <= `VBUS_5V_MV;
        programmable_supply_contract <= 1'b0;
        limit_ma <= `CURR_3A_MA;
      end else begin
        case (state)
          ST_UNATT: begin
            cc_adv_out <= `ADV_3A;
            if (attach_s2) begin
              gate_drive_out <= 1'b1;
              discharge_out <= 1'b0;
              vbus_target_out <= `VBUS_5V_MV;
              state <= ST_CAPS;
              timer <= 32'h0;
            end
          end
          ST_CAPS: begin
            send_caps_out <= 1'b1;
            caps_on_cc2_out <= orient_cc2_in;
            state <= ST_WAIT;
          end
          ST_WAIT: begin
            if (request_valid_in && request_legal_in) begin
              send_accept_out <= 1'b1;
              vbus_target_out <= request_mv_in;
              limit_ma <= request_ma_in;
              programmable_supply_contract <= request_pps_in;
              state <= ST_CONTRACT;
            end else if (request_valid_in) begin
              send_reject_out <= 1'b1;
              timer <= 32'h0;
              state <= ST_REJECT;
            end else if (timer >= NO_ANSWER_LIM) begin
              state <= ST_TYPEC;
            end
          end
          ST_REJECT: begin
            if (timer >= RESEND_CYCLES) begin
              state <= ST_CAPS;
              timer <= 32'h0;
            end
          end
          ST_TYPEC: begin
            // Legacy sinks: 5 V, 3 A limit kept
            vbus_target_out <= `VBUS_5V_MV;
          end
          ST_CONTRACT: begin
            if (request_valid_in && request_legal_in) begin
              send_accept_out <= 1'b1;
              vbus_target_out <= request_mv_in;
              limit_ma <= request_ma_in;
              programmable_supply_contract <= request_pps_in;
            end else if (request_valid_in) begin
              send_reject_out <= 1'b1;
              timer <= 32'h0;
              state <= ST_REJECT;
            end
          end
          ST_DISABLED: begin
            // Stays off until the detector clears and the sink leaves
            if (!attach_s2) begin
              state <= ST_UNATT;
              disabled_out <= 1'b0;
              cc_adv_out <= `ADV_3A;
            end
          end
          default: state <= ST_UNATT;
        endcase
      end
    end
  end

  feedback_servo #(.WIDTH(16)) feedback_servo_inst (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .target_mv_in(vbus_target_out + comp_mv),
    .sense_mv_in(voltage_feedback_sense_in),
    .drive_out(servo_drive)
  );

  // Current protection, limiting and status reports
  always @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      regulator_feedback_drive_out <= 16'h0000;
      current_limit_out <= 1'b0;
      ocp_fault_out <= 1'b0;
      send_status_out <= 1'b0;
      status_current_out <= 10'h000;
      status_voltage_out <= 10'h000;
      legacy_mode_out <= `LEG_NONE;
    end else begin
      regulator_feedback_drive_out <= servo_drive;
      current_limit_out <= programmable_supply_contract && (current_sense_ma_in > limit_ma);
      if (!gate_drive_out) begin
        ocp_fault_out <= 1'b0;
      end else if (!programmable_supply_contract && current_sense_ma_in > limit_ma) begin
        ocp_fault_out <= 1'b1;
      end
      send_status_out <= 1'b0;
      if (status_req_in && programmable_supply_contract && state == ST_CONTRACT) begin
        status_current_out <= adc_current_in;
        status_voltage_out <= adc_rail_in;
        send_status_out <= 1'b1;
      end
      if (!legacy_divider_cfg_in) begin
        legacy_mode_out <= `LEG_NONE;
      end else if (div_s2) begin
        legacy_mode_out <= `LEG_DIVIDER;
      end else begin
        legacy_mode_out <= `LEG_SHORT;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/policy_chk.sv
// Port checker for the source attach policy block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module policy_chk (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic attach_in,
  input wire logic orient_cc2_in,
  input wire logic cc_ovp_in,
  input wire logic request_valid_in,
  input wire logic request_legal_in,
  input wire logic gate_drive_out,
  input wire logic discharge_out,
  input wire logic [1:0] cc_adv_out,
  input wire logic send_caps_out,
  input wire logic caps_on_cc2_out,
  input wire logic send_reject_out,
  input wire logic disabled_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  attach_gate_a: assert property (
    (attach_in && !cc_ovp_in && !disabled_out)[*5] |-> gate_drive_out) else $error("no gate");
  adv_level_a: assert property (gate_drive_out |-> cc_adv_out == 2'h3)
    else $error("bad advert");
  caps_after_a: assert property ($rose(gate_drive_out) |-> ##[0:2] send_caps_out)
    else $error("no offer");
  caps_line_a: assert property (send_caps_out |-> caps_on_cc2_out == orient_cc2_in)
    else $error("wrong line");
  detach_off_a: assert property (
    !attach_in[*5] |-> !gate_drive_out && discharge_out) else $error("still on");
  ovp_off_a: assert property ((cc_ovp_in && attach_in)[*5] |->
    !gate_drive_out && disabled_out && cc_adv_out == 2'h0) else $error("not off");
  reject_cause_a: assert property (
    send_reject_out |-> $past(request_valid_in) && !$past(request_legal_in)) else $error("why");
  resend_a: assert property (send_reject_out |-> ##[1:420] send_caps_out)
    else $error("no resend");
  cover property (send_reject_out);
  cover property (send_caps_out && caps_on_cc2_out);
  cover property (disabled_out);
endmodule
bind pd_source_attach_policy policy_chk policy_chk_inst (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .attach_in(attach_in),
  .orient_cc2_in(orient_cc2_in), .cc_ovp_in(cc_ovp_in), .request_valid_in(request_valid_in),
  .request_legal_in(request_legal_in), .gate_drive_out(gate_drive_out),
  .discharge_out(discharge_out), .cc_adv_out(cc_adv_out), .send_caps_out(send_caps_out),
  .caps_on_cc2_out(caps_on_cc2_out), .send_reject_out(send_reject_out),
  .disabled_out(disabled_out));
`default_nettype wire

// ===== sim/sink_model.sv
// Sink partner: answers each offer with one request while answer_in is high.
// Assumes offers are one-cycle pulses; drives at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module sink_model (
  input wire logic core_clk_in,
  input wire logic send_caps_in,
  input wire logic answer_in,
  input wire logic legal_in,
  output var logic request_valid_out,
  output var logic request_legal_out
);
  int cnt = -1;
  // request after delay; qualifier inverted when idle
  always @(negedge core_clk_in) begin
    request_valid_out <= (cnt == 0);
    request_legal_out <= (cnt == 0) ? legal_in : !legal_in;
    if (send_caps_in && answer_in)
      cnt <= 20;
    else if (cnt >= 0)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// ===== sim/pd_source_attach_policy_tb.sv
// Testbench for the source attach policy block.
// Assumes the sink model and checker; short no-answer time.
`timescale 1ns/100ps
`default_nettype none
module pd_source_attach_policy_tb;
  logic core_clk_in = 0, reset_n_in = 0, attach_in = 0, orient_cc2_in = 0, cc_ovp_in = 0;
  logic request_pps_in = 1, status_req_in = 0, answer = 0, legal = 0, legacy_cfg = 1;
  logic [15:0] sense_ma = 16'h0064;
  logic comp_cfg = 0, div_seen = 0, ocp;
  logic [15:0] fb_sense = 16'h1300, fb_drive;
  logic request_valid_in, request_legal_in, gate, disch, caps, cc2, rej, acc, stat, lim, dis;
  logic [1:0] adv, leg;
  logic [15:0] target;
  logic [9:0] s_cur, s_volt;
  int n_errors = 0, n_compared = 0, n_caps = 0;
  always #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (caps === 1'b1) n_caps++;
  pd_source_attach_policy #(.NO_ANSWER_CYCLES(50)) pd_source_attach_policy_inst (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .attach_in(attach_in),
    .orient_cc2_in(orient_cc2_in), .cc_ovp_in(cc_ovp_in), .request_valid_in(request_valid_in),
    .request_legal_in(request_legal_in), .request_pps_in(request_pps_in),
    .request_mv_in(16'h1388), .request_ma_in(16'h07d0), .status_req_in(status_req_in),
    .voltage_feedback_sense_in(fb_sense), .current_sense_ma_in(sense_ma),
    .adc_current_in(10'h155), .adc_rail_in(10'h2aa), .legacy_divider_cfg_in(legacy_cfg),
    .cable_comp_cfg_in(comp_cfg), .dm_dp_divider_seen_in(div_seen), .gate_drive_out(gate),
    .discharge_out(disch), .cc_adv_out(adv), .vbus_target_out(target), .send_caps_out(caps),
    .caps_on_cc2_out(cc2), .send_reject_out(rej), .send_accept_out(acc),
    .send_status_out(stat), .status_current_out(s_cur), .status_voltage_out(s_volt),
    .regulator_feedback_drive_out(fb_drive), .current_limit_out(lim), .ocp_fault_out(ocp),
    .legacy_mode_out(leg), .disabled_out(dis));
  sink_model sink_model_inst (.core_clk_in(core_clk_in), .send_caps_in(caps),
    .answer_in(answer), .legal_in(legal), .request_valid_out(request_valid_in),
    .request_legal_out(request_legal_in));
  task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait on a pulse: 0 offer, 1 reject, 2 accept, 3 status
  task automatic wait_for(input int sel);
    logic [3:0] f;
    for (int i = 0; i < 500; i++) begin
      @(negedge core_clk_in);
      f = {stat, acc, rej, caps};
      if (f[sel] === 1'b1) return;
    end
    compare("pulse wait", 16'h0001, 16'h0000);
  endtask
  // Silent sink on the second line, shorted data lines
  task automatic t_silent;
    int seen;
    logic [15:0] d;
    seen = n_caps;
    orient_cc2_in = 1;
    attach_in = 1;
    wait_for(0);
    compare("gate", 1, gate);
    compare("cc2", 1, cc2);
    compare("target", 16'h1388, target);
    repeat (80) @(negedge core_clk_in);
    compare("offers", seen + 1, n_caps);
    compare("gate held", 1, gate);
    compare("legacy", 16'h0001, leg);
    compare("legacy 5V", 16'h1388, target);
    // Sense at target holds the drive, sense above it pulls the drive down
    fb_sense = 16'h1388;
    repeat (2) @(negedge core_clk_in);
    d = fb_drive;
    repeat (4) @(negedge core_clk_in);
    compare("fb hold", d, fb_drive);
    fb_sense = 16'h1400;
    repeat (4) @(negedge core_clk_in);
    compare("fb down", 1, fb_drive < d);
    // Shorted-line legacy sink draws its 1.5 A
    sense_ma = 16'h05dc;
    repeat (3) @(negedge core_clk_in);
    compare("legacy 1.5A", 0, ocp);
    // Cable compensation lifts the target above the sensed rail
    d = fb_drive;
    comp_cfg = 1;
    sense_ma = 16'h0bb8;
    repeat (4) @(negedge core_clk_in);
    compare("cable comp", 1, fb_drive > d);
    compare("legacy 3A", 0, ocp);
    sense_ma = 16'h0bb9;
    repeat (3) @(negedge core_clk_in);
    compare("ocp", 1, ocp);
    div_seen = 1;
    repeat (4) @(negedge core_clk_in);
    compare("divider", 16'h0002, leg);
    attach_in = 0;
    comp_cfg = 0;
    sense_ma = 16'h0064;
    repeat (5) @(negedge core_clk_in);
    compare("gate off", 0, gate);
    compare("discharge", 1, disch);
    compare("ocp clear", 0, ocp);
  endtask
  // Bad request, resend, good request, status, limit, over-voltage
  task automatic t_contract;
    orient_cc2_in = 0;
    answer = 1;
    legal = 0;
    attach_in = 1;
    wait_for(0);
    compare("cc1", 0, cc2);
    wait_for(1);
    legal = 1;
    wait_for(0);
    wait_for(2);
    // The status pulse stands one cycle: look at the first falling edge
    status_req_in = 1;
    wait_for(3);
    status_req_in = 0;
    compare("stat cur", 16'h0155, s_cur);
    compare("stat volt", 16'h02aa, s_volt);
    sense_ma = 16'h0bb8;
    repeat (4) @(negedge core_clk_in);
    compare("limit", 1, lim);
    cc_ovp_in = 1;
    repeat (6) @(negedge core_clk_in);
    compare("ovp gate", 0, gate);
    compare("ovp dis", 1, dis);
    compare("ovp adv", 0, adv);
    compare("ovp limit", 0, lim);
    cc_ovp_in = 0;
    attach_in = 0;
    repeat (5) @(negedge core_clk_in);
  endtask
  task automatic complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk_in);
    reset_n_in = 1;
    compare("reset gate", 0, gate);
    compare("reset adv", 3, adv);
    t_silent;
    t_contract;
    complete_run;
  end
  // Watchdog far beyond the expected run of about 600 cycles
  initial begin
    #200000;
    n_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
